// *** logic/ppr_regulator.sv ***
// Process closed-loop regulator producing a signed output frequency command.
`timescale 1ns/1ns
// Function
// - Target picked from seven sources, one reserved zero.
// - Fixed target 0..100 %, default 50 %.
// - Feedback picked from nine sources, one reserved zero.
// - Direction bit sets sign of action.
// - Reversal pin inverts configured direction.
// - Display scales 100 % to display range.
// - Gain 100.0 at 100 % gives max frequency.
// - Integral reaches max after integration time.
// - Differential gives max for 100 % in time.
// - Negative output clamped to reverse cutoff.
// - Inside dead band regulator holds output.
// - Differential term clamped to differential limit.
// - Target ramps 100 % per change time.
// - Feedback passes through first-order low-pass.
// - Output passes through first-order low-pass.
// - Evaluate once every 2 ms beat.
module ppr_regulator
	import ppr_pkg::*;
#(
	parameter int unsigned BEAT_CYCLES = BEAT_TIME_NS / CLK_PERIOD_NS,
	parameter int          PW          = 16
)(
	// Clock and reset.
	input  wire logic                mclk,
	input  wire logic                reset_n,
	// Register port.
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr_stb,
	input  wire logic                rd_stb,
	output logic      [31:0]         rdata_ff,
	// Percent inputs in 0.1 % steps.
	input  wire logic [PW-1:0]       analog_voltage_input_one,
	input  wire logic [PW-1:0]       analog_input_two,
	input  wire logic [PW-1:0]       pulse_input_terminal,
	input  wire logic [PW-1:0]       comm_value,
	input  wire logic [PW-1:0]       multi_step_value,
	// Direction reversal terminal.
	input  wire logic                dir_reverse_in,
	// Frequency command out.
	output logic signed [31:0]       freq_cmd_ff,
	output logic                     beat_ff
);

	// ------------------------------------------------------------
	// Settings registers.
	// ------------------------------------------------------------
	logic [8:0]  ctrl_ff;      // Sources and direction.
	logic [15:0] fix_tgt_ff;   // Fixed target.
	logic [15:0] disp_rng_ff;  // Display range.
	logic [15:0] kp_ff;        // Proportional gain.
	logic [15:0] ti_ff;        // Integration time.
	logic [15:0] td_ff;        // Differential time.
	logic [15:0] rev_cut_ff;   // Reverse cutoff.
	logic [15:0] dev_lim_ff;   // Dead band.
	logic [15:0] diff_lim_ff;  // Differential limit.
	logic [15:0] ramp_t_ff;    // Target change time.
	logic [15:0] fb_filt_ff;   // Feedback filter time.
	logic [15:0] out_filt_ff;  // Output filter time.
	logic [15:0] max_freq_ff;  // Maximum frequency.

	// ------------------------------------------------------------
	// Regulator state; target and feedback in fine units (0.1 % times FINE).
	// ------------------------------------------------------------
	logic [19:0]          beat_cnt_ff;  // Beat divider.
	logic signed [63:0]   tgt_ff;       // Applied target.
	logic signed [63:0]   fbf_ff;       // Filtered feedback.
	logic signed [63:0]   iacc_ff;      // Integral accumulator.
	logic signed [63:0]   ofilt_ff;     // Filtered output, freq times FINE.
	logic signed [63:0]   uhold_ff;     // Last unfiltered output.
	logic [31:0]          disp_tgt_ff;  // Display target.
	logic [31:0]          disp_fb_ff;   // Display feedback.

	// Combinational results.
	logic signed [63:0]   nxt_tgt, nxt_fbf, nxt_iacc, nxt_ofilt, nxt_u;

	// Beat strobe from the divider.
	logic beat_now;
	assign beat_now = (32'(beat_cnt_ff) == BEAT_CYCLES - 1);

	// ------------------------------------------------------------
	// Register writes; unmapped addresses are ignored.
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_ff     <= 9'h000;
			fix_tgt_ff  <= RST_FIX_TGT;
			disp_rng_ff <= RST_DISP_RANGE;
			kp_ff       <= RST_KP;
			ti_ff       <= RST_TI;
			td_ff       <= RST_TD;
			rev_cut_ff  <= RST_REV_CUT;
			dev_lim_ff  <= RST_DEV_LIM;
			diff_lim_ff <= RST_DIFF_LIM;
			ramp_t_ff   <= RST_ZERO;
			fb_filt_ff  <= RST_ZERO;
			out_filt_ff <= RST_ZERO;
			max_freq_ff <= RST_MAX_FREQ;
		end
		else if (wr_stb)
		begin
			unique case (addr)
				OFS_CTRL:       ctrl_ff     <= wdata[8:0];
				OFS_FIX_TGT:    fix_tgt_ff  <= (wdata[15:0] > PCT_FULL) ? PCT_FULL : wdata[15:0];
				OFS_DISP_RANGE: disp_rng_ff <= wdata[15:0];
				OFS_KP:         kp_ff       <= wdata[15:0];
				OFS_TI:         ti_ff       <= wdata[15:0];
				OFS_TD:         td_ff       <= wdata[15:0];
				OFS_REV_CUT:    rev_cut_ff  <= wdata[15:0];
				OFS_DEV_LIM:    dev_lim_ff  <= wdata[15:0];
				OFS_DIFF_LIM:   diff_lim_ff <= wdata[15:0];
				OFS_RAMP_T:     ramp_t_ff   <= wdata[15:0];
				OFS_FB_FILT:    fb_filt_ff  <= wdata[15:0];
				OFS_OUT_FILT:   out_filt_ff <= wdata[15:0];
				OFS_MAX_FREQ:   max_freq_ff <= wdata[15:0];
				default:        ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data, valid only in the cycle after the strobe.
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_ff <= 32'h0000_0000;
		else if (rd_stb)
		begin
			unique case (addr)
				OFS_CTRL:       rdata_ff <= {23'h000000, ctrl_ff};
				OFS_FIX_TGT:    rdata_ff <= {16'h0000, fix_tgt_ff};
				OFS_DISP_RANGE: rdata_ff <= {16'h0000, disp_rng_ff};
				OFS_KP:         rdata_ff <= {16'h0000, kp_ff};
				OFS_TI:         rdata_ff <= {16'h0000, ti_ff};
				OFS_TD:         rdata_ff <= {16'h0000, td_ff};
				OFS_REV_CUT:    rdata_ff <= {16'h0000, rev_cut_ff};
				OFS_DEV_LIM:    rdata_ff <= {16'h0000, dev_lim_ff};
				OFS_DIFF_LIM:   rdata_ff <= {16'h0000, diff_lim_ff};
				OFS_RAMP_T:     rdata_ff <= {16'h0000, ramp_t_ff};
				OFS_FB_FILT:    rdata_ff <= {16'h0000, fb_filt_ff};
				OFS_OUT_FILT:   rdata_ff <= {16'h0000, out_filt_ff};
				OFS_MAX_FREQ:   rdata_ff <= {16'h0000, max_freq_ff};
				OFS_ST_FREQ:    rdata_ff <= freq_cmd_ff;
				OFS_ST_TGT:     rdata_ff <= 32'(tgt_ff / FINE);
				OFS_ST_FB:      rdata_ff <= 32'(fbf_ff / FINE);
				OFS_ST_DTGT:    rdata_ff <= disp_tgt_ff;
				OFS_ST_DFB:     rdata_ff <= disp_fb_ff;
				default:        rdata_ff <= 32'h0000_0000;
			endcase
		end
		else
			rdata_ff <= 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// Beat divider: one evaluation per 2 ms.
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			beat_cnt_ff <= 20'h00000;
			beat_ff     <= 1'b0;
		end
		else
		begin
			beat_cnt_ff <= beat_now ? 20'h00000 : beat_cnt_ff + 20'h00001;
			beat_ff     <= beat_now;
		end
	end

	// ------------------------------------------------------------
	// One beat of the regulator, evaluated in a single cycle so the
	// settings of that cycle are used throughout. Wide dividers are
	// the price of doing it in one step instead of a sequencer.
	// ------------------------------------------------------------
	always_comb
	begin
		logic signed [63:0] a1, a2, tsel, fsel, goal, step, e, dfb, p, ival, d, dlim, fmax, ilim;
		logic signed [63:0] kp, ti, td, rc, fbt, oft, pct; // Signed copies keep negative terms signed.
		logic               rev;
		a1    = 64'(analog_voltage_input_one);
		a2    = 64'(analog_input_two);
		fmax  = 64'(max_freq_ff);
		// Unsigned settings would turn every product with a deviation unsigned.
		kp    = $signed(64'(kp_ff));
		ti    = $signed(64'(ti_ff));
		td    = $signed(64'(td_ff));
		rc    = $signed(64'(rev_cut_ff));
		fbt   = $signed(64'(fb_filt_ff));
		oft   = $signed(64'(out_filt_ff));
		pct   = $signed(64'(PCT_FULL));
		// Target source.
		unique case (ppr_tsrc_t'(ctrl_ff[CTRL_TSRC_LSB +: 4]))
			TS_FIXED: tsel = 64'(fix_tgt_ff);
			TS_AIN1:  tsel = a1;
			TS_AIN2:  tsel = a2;
			TS_PULSE: tsel = 64'(pulse_input_terminal);
			TS_COMM:  tsel = 64'(comm_value);
			TS_STEP:  tsel = 64'(multi_step_value);
			default:  tsel = 64'sd0;
		endcase
		// Feedback source.
		unique case (ppr_fsrc_t'(ctrl_ff[CTRL_FSRC_LSB +: 4]))
			FS_AIN1:  fsel = a1;
			FS_AIN2:  fsel = a2;
			FS_DIFF:  fsel = a1 - a2;
			FS_PULSE: fsel = 64'(pulse_input_terminal);
			FS_COMM:  fsel = 64'(comm_value);
			FS_SUM:   fsel = a1 + a2;
			FS_MAX:   fsel = (a1 > a2) ? a1 : a2;
			FS_MIN:   fsel = (a1 < a2) ? a1 : a2;
			default:  fsel = 64'sd0;
		endcase
		// Relative values stay inside 0..100 %.
		if (tsel > 64'(PCT_FULL)) tsel = 64'(PCT_FULL);
		if (fsel < 64'sd0) fsel = 64'sd0;
		if (fsel > 64'(PCT_FULL)) fsel = 64'(PCT_FULL);
		// Target ramp at 100 % per change time.
		goal = tsel * FINE;
		step = (ramp_t_ff == 16'h0000) ? 64'(PCT_FULL) * FINE :
			(64'(PCT_FULL) * FINE * BEAT_MS) / (64'(ramp_t_ff) * TI_UNIT_MS);
		if (goal > tgt_ff + step)      nxt_tgt = tgt_ff + step;
		else if (goal < tgt_ff - step) nxt_tgt = tgt_ff - step;
		else                           nxt_tgt = goal;
		// Feedback low-pass.
		nxt_fbf = fbf_ff + ((fsel * FINE - fbf_ff) * BEAT_MS) /
			(fbt * TI_UNIT_MS + BEAT_MS);
		// Deviation, sign set by direction and reversal pin.
		rev = ctrl_ff[CTRL_DIR_BIT] ^ dir_reverse_in;
		e   = rev ? nxt_fbf - nxt_tgt : nxt_tgt - nxt_fbf;
		dfb = rev ? nxt_fbf - fbf_ff : fbf_ff - nxt_fbf;
		// Proportional: gain 100.0 at full deviation gives max frequency.
		p = (kp * e * fmax) / (pct * pct * FINE);
		// Integral: full deviation for Ti reaches max frequency.
		ilim = 64'(ti_ff) * TI_UNIT_MS * 64'(PCT_FULL) * FINE * fmax / BEAT_MS;
		if (ti_ff == 16'h0000)
			nxt_iacc = 64'sd0;
		else
		begin
			nxt_iacc = iacc_ff + e * fmax;
			if (nxt_iacc > ilim)  nxt_iacc = ilim;
			if (nxt_iacc < -ilim) nxt_iacc = -ilim;
		end
		ival = (ti_ff == 16'h0000) ? 64'sd0 :
			(nxt_iacc * BEAT_MS) / (ti * TI_UNIT_MS * pct * FINE);
		// Differential on feedback change, full change in Td gives max.
		d    = (dfb * fmax * td) / (BEAT_MS * pct * FINE);
		dlim = (64'(diff_lim_ff) * fmax) / DIFF_FULL;
		if (d > dlim)  d = dlim;
		if (d < -dlim) d = -dlim;
		// Sum and saturate.
		nxt_u = p + ival + d;
		if (nxt_u > fmax) nxt_u = fmax;
		if (nxt_u < -rc) nxt_u = -rc;
		// Dead band: hold integral and output when deviation is small.
		if ((e < 0 ? -e : e) < 64'(dev_lim_ff) * FINE)
		begin
			nxt_u    = uhold_ff;
			nxt_iacc = iacc_ff;
		end
		// Output low-pass.
		nxt_ofilt = ofilt_ff + ((nxt_u * FINE - ofilt_ff) * BEAT_MS) /
			(oft * TI_UNIT_MS + BEAT_MS);
	end

	// ------------------------------------------------------------
	// Beat update of regulator state.
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tgt_ff   <= 64'sd0;
			fbf_ff   <= 64'sd0;
			iacc_ff  <= 64'sd0;
			ofilt_ff <= 64'sd0;
			uhold_ff <= 64'sd0;
		end
		else if (beat_now)
		begin
			tgt_ff   <= nxt_tgt;
			fbf_ff   <= nxt_fbf;
			iacc_ff  <= nxt_iacc;
			ofilt_ff <= nxt_ofilt;
			uhold_ff <= nxt_u;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs: command and display values.
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			freq_cmd_ff <= 32'sd0;
			disp_tgt_ff <= 32'h0000_0000;
			disp_fb_ff  <= 32'h0000_0000;
		end
		else
		begin
			freq_cmd_ff <= 32'(ofilt_ff / FINE);
			disp_tgt_ff <= 32'((tgt_ff * 64'(disp_rng_ff)) / (64'(PCT_FULL) * FINE));
			disp_fb_ff  <= 32'((fbf_ff * 64'(disp_rng_ff)) / (64'(PCT_FULL) * FINE));
		end
	end

endmodule

// *** shared/ppr_pkg.sv ***
// Constants shared by the process regulator: register map, reset values and timing.
package ppr_pkg;

	// ------------------------------------------------------------
	// Register byte offsets.
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL       = 8'h00; // Sources and direction.
	localparam logic [7:0] OFS_FIX_TGT    = 8'h04; // Fixed target, 0.1 %.
	localparam logic [7:0] OFS_DISP_RANGE = 8'h08; // Display range.
	localparam logic [7:0] OFS_KP         = 8'h0C; // Proportional gain, 0.1.
	localparam logic [7:0] OFS_TI         = 8'h10; // Integration time, 10 ms.
	localparam logic [7:0] OFS_TD         = 8'h14; // Differential time, 1 ms.
	localparam logic [7:0] OFS_REV_CUT    = 8'h18; // Reverse cutoff, 0.01 Hz.
	localparam logic [7:0] OFS_DEV_LIM    = 8'h1C; // Deviation dead band, 0.1 %.
	localparam logic [7:0] OFS_DIFF_LIM   = 8'h20; // Differential limit, 0.01 %.
	localparam logic [7:0] OFS_RAMP_T     = 8'h24; // Target change time, 10 ms.
	localparam logic [7:0] OFS_FB_FILT    = 8'h28; // Feedback filter time, 10 ms.
	localparam logic [7:0] OFS_OUT_FILT   = 8'h2C; // Output filter time, 10 ms.
	localparam logic [7:0] OFS_MAX_FREQ   = 8'h30; // Maximum frequency, 0.01 Hz.
	localparam logic [7:0] OFS_ST_FREQ    = 8'h40; // Frequency command, signed.
	localparam logic [7:0] OFS_ST_TGT     = 8'h44; // Applied target, 0.1 %.
	localparam logic [7:0] OFS_ST_FB      = 8'h48; // Filtered feedback, 0.1 %.
	localparam logic [7:0] OFS_ST_DTGT    = 8'h4C; // Target in display units.
	localparam logic [7:0] OFS_ST_DFB     = 8'h50; // Feedback in display units.

	// ------------------------------------------------------------
	// Control register fields.
	// ------------------------------------------------------------
	localparam int CTRL_TSRC_LSB = 0; // Target source, 4 bits.
	localparam int CTRL_FSRC_LSB = 4; // Feedback source, 4 bits.
	localparam int CTRL_DIR_BIT  = 8; // Action direction.

	// ------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------
	localparam logic [15:0] RST_FIX_TGT    = 16'h01F4; // 50.0 %.
	localparam logic [15:0] RST_DISP_RANGE = 16'h03E8; // 1000.
	localparam logic [15:0] RST_KP         = 16'h00C8; // 20.0.
	localparam logic [15:0] RST_TI         = 16'h00C8; // 2.00 s.
	localparam logic [15:0] RST_TD         = 16'h0000; // 0.000 s.
	localparam logic [15:0] RST_REV_CUT    = 16'h0000; // 0.00 Hz.
	localparam logic [15:0] RST_DEV_LIM    = 16'h0000; // 0.0 %.
	localparam logic [15:0] RST_DIFF_LIM   = 16'h0032; // 0.50 %.
	localparam logic [15:0] RST_ZERO       = 16'h0000; // Times default to zero.
	localparam logic [15:0] RST_MAX_FREQ   = 16'h1388; // Plain default, 50.00 Hz.

	// ------------------------------------------------------------
	// Scaling and timing.
	// ------------------------------------------------------------
	localparam logic [15:0] PCT_FULL     = 16'h03E8; // 100.0 % in 0.1 % steps.
	localparam longint      FINE         = 1000;     // Internal fraction per 0.1 %.
	localparam longint      BEAT_MS      = 2;        // Control beat.
	localparam longint      TI_UNIT_MS   = 10;       // Step of time settings.
	localparam longint      DIFF_FULL    = 10000;    // 100.00 % limit steps.
	localparam int          CLK_PERIOD_NS = 4;       // 250 MHz.
	localparam int          BEAT_TIME_NS = 2000000;  // 2 ms.

	// Source selections.
	typedef enum logic [3:0] {TS_FIXED, TS_AIN1, TS_AIN2, TS_RSVD, TS_PULSE, TS_COMM, TS_STEP} ppr_tsrc_t;
	typedef enum logic [3:0] {FS_AIN1, FS_AIN2, FS_RSVD, FS_DIFF, FS_PULSE, FS_COMM, FS_SUM, FS_MAX,
		FS_MIN} ppr_fsrc_t;

endpackage

// *** tb/ppr_regulator_props.sv ***
// Concurrent checks on the regulator's ports.
`timescale 1ns/1ns
module ppr_regulator_props
	import ppr_pkg::*;
#(
	parameter int unsigned BEAT_CYCLES = 8
)(
	// Clock and reset.
	input wire logic               mclk,
	input wire logic               reset_n,
	// Register port.
	input wire logic [7:0]         addr,
	input wire logic [31:0]        wdata,
	input wire logic               wr_stb,
	input wire logic               rd_stb,
	input wire logic [31:0]        rdata_ff,
	// Command out.
	input wire logic signed [31:0] freq_cmd_ff,
	input wire logic               beat_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	logic [31:0] gap_ff;  // Cycles since the last beat pulse.
	logic        seen_ff; // The first beat has passed, so the gap is meaningful.
	logic [8:0]  ctrl_ff; // Shadow of the control register.
	logic [15:0] max_ff;  // Shadow of the maximum frequency.
	logic [15:0] rev_ff;  // Shadow of the reverse cutoff.

	// Beat spacing counter.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gap_ff  <= 32'h0;
			seen_ff <= 1'b0;
		end
		else
		begin
			gap_ff  <= beat_ff ? 32'h0 : gap_ff + 32'h1;
			seen_ff <= seen_ff | beat_ff;
		end
	end

	// Setting shadows, fed from the same strobes the design sees.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_ff <= 9'h000;
			max_ff  <= RST_MAX_FREQ;
			rev_ff  <= RST_REV_CUT;
		end
		else if (wr_stb)
		begin
			if (addr == OFS_CTRL) ctrl_ff <= wdata[8:0];
			if (addr == OFS_MAX_FREQ) max_ff <= wdata[15:0];
			if (addr == OFS_REV_CUT) rev_ff <= wdata[15:0];
		end
	end

	sequence s_read(logic [7:0] a);
		rd_stb && addr == a;
	endsequence

	a_beat_single: assert property (beat_ff |=> !beat_ff)
		else $error("beat pulse longer than one cycle");
	a_beat_period: assert property (seen_ff && beat_ff |-> gap_ff == BEAT_CYCLES - 1)
		else $error("beat spacing wrong");
	a_freq_beat_only: assert property ($changed(freq_cmd_ff) |-> $past(beat_ff))
		else $error("command changed between beats");
	a_rdata_idle: assert property (!rd_stb |=> rdata_ff == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (s_read(8'h3C) |=> rdata_ff == 32'h0)
		else $error("unmapped read not zero");
	a_fixtgt_clamp: assert property (s_read(OFS_FIX_TGT) |=> rdata_ff <= 32'h3E8)
		else $error("fixed target above full scale");
	a_ctrl_readback: assert property (s_read(OFS_CTRL) |=> rdata_ff[8:0] == $past(ctrl_ff))
		else $error("control readback wrong");
	a_freq_bounds: assert property (beat_ff |-> freq_cmd_ff <= $signed({16'h0000, $past(max_ff)})
		&& freq_cmd_ff >= -$signed({16'h0000, $past(rev_ff)}))
		else $error("command outside saturation range");
endmodule

bind ppr_regulator ppr_regulator_props #(.BEAT_CYCLES(BEAT_CYCLES)) u_ppr_regulator_props (
	.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata_ff(rdata_ff), .freq_cmd_ff(freq_cmd_ff), .beat_ff(beat_ff));

// *** tb/ppr_source_model.sv ***
// Model of the analog, pulse, communication and step sources.
`timescale 1ns/1ns
module ppr_source_model (
	// Clock.
	input  wire logic  mclk,
	// Values in 0.1 % steps.
	output logic [15:0] analog_voltage_input_one,
	output logic [15:0] analog_input_two,
	output logic [15:0] pulse_input_terminal,
	output logic [15:0] comm_value,
	output logic [15:0] multi_step_value
);
	// Sources settle at zero before the first beat.
	initial
	begin
		analog_voltage_input_one = 16'h0000;
		analog_input_two = 16'h0000;
		pulse_input_terminal = 16'h0000;
		comm_value = 16'h0000;
		multi_step_value = 16'h0000;
	end

	// New levels land just after an edge, as a sampled converter would.
	task automatic set_src(input logic [15:0] a1, a2, pl, cm, st);
		@(posedge mclk);
		analog_voltage_input_one <= a1;
		analog_input_two <= a2;
		pulse_input_terminal <= pl;
		comm_value <= cm;
		multi_step_value <= st;
	endtask
endmodule

// *** tb/ppr_regulator_tb_top.sv ***
// Self-checking bench for the process regulator.
`timescale 1ns/1ns
module ppr_regulator_tb_top
	import ppr_pkg::*;
;
	localparam int unsigned BC = 8; // Short beat keeps the run brief.
	logic mclk, reset_n, wr_stb, rd_stb, dir_reverse_in, beat_ff;
	logic [7:0] addr;
	logic [31:0] wdata, rdata_ff, v;
	logic [15:0] a1, a2, pl, cm, st;
	logic signed [31:0] freq_cmd_ff;
	int n_errors, n_compared;

	ppr_regulator #(.BEAT_CYCLES(BC), .PW(16)) u_ppr_regulator (.mclk(mclk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
		.analog_voltage_input_one(a1), .analog_input_two(a2), .pulse_input_terminal(pl),
		.comm_value(cm), .multi_step_value(st), .dir_reverse_in(dir_reverse_in),
		.freq_cmd_ff(freq_cmd_ff), .beat_ff(beat_ff));
	ppr_source_model u_ppr_source_model (.mclk(mclk), .analog_voltage_input_one(a1),
		.analog_input_two(a2), .pulse_input_terminal(pl), .comm_value(cm), .multi_step_value(st));

	always #2 mclk = ~mclk;

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 v = rdata_ff;
		if (nm != "") chk(nm, e, v);
	endtask

	// Waits for n beat pulses, bounded so a dead beat cannot hang the run.
	task automatic beats(input int n);
		int k;
		k = 0;
		for (int i = 0; i < n * 4 * BC && k < n; i++)
		begin
			@(posedge mclk);
			#1 if (beat_ff === 1'b1) k++;
		end
		if (k < n)
		begin
			n_errors++;
			$display("BAD beat count expected %0d seen %0d", n, k);
			conclude();
		end
	endtask

	task automatic conclude;
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic t_defaults;
		rd(OFS_FIX_TGT, 32'h1F4, "fixed target");
		rd(OFS_DISP_RANGE, 32'h3E8, "display range");
		rd(OFS_KP, 32'hC8, "gain");
		rd(OFS_TI, 32'hC8, "integration time");
		rd(OFS_TD, 32'h0, "differential time");
		rd(OFS_DIFF_LIM, 32'h32, "differential limit");
		rd(8'h3C, 32'h0, "unmapped");
	endtask

	// Every target and feedback source, reserved codes included.
	task automatic t_sources;
		logic [15:0] te [0:6];
		logic [15:0] fe [0:8];
		te = '{16'h01F4, 16'h0258, 16'h012C, 16'h0000, 16'h007B, 16'h01C8, 16'h0315};
		fe = '{16'h0258, 16'h012C, 16'h0000, 16'h012C, 16'h007B, 16'h01C8, 16'h0384, 16'h0258, 16'h012C};
		wr(OFS_TI, 32'h0);
		u_ppr_source_model.set_src(16'h0258, 16'h012C, 16'h007B, 16'h01C8, 16'h0315);
		for (int i = 0; i < 7; i++)
		begin
			wr(OFS_CTRL, 32'(i));
			beats(2);
			rd(OFS_ST_TGT, {16'h0000, te[i]}, "target source");
		end
		for (int i = 0; i < 9; i++)
		begin
			wr(OFS_CTRL, 32'(i) << 4);
			beats(2);
			rd(OFS_ST_FB, {16'h0000, fe[i]}, "feedback source");
		end
		wr(OFS_CTRL, 32'h0);
		wr(OFS_DISP_RANGE, 32'h7D0);
		beats(2);
		rd(OFS_ST_DTGT, 32'h3E8, "display target");
		rd(OFS_ST_DFB, 32'h4B0, "display feedback");
	endtask

	// Proportional action, direction, reversal pin, cutoff and saturation.
	task automatic t_action;
		u_ppr_source_model.set_src(16'h0000, 16'h012C, 16'h007B, 16'h01C8, 16'h0315);
		beats(2);
		chk("proportional", 32'h1F4, freq_cmd_ff);
		wr(OFS_FIX_TGT, 32'h3E8);
		wr(OFS_KP, 32'h7D0);
		beats(2);
		chk("saturated", 32'h1388, freq_cmd_ff);
		wr(OFS_KP, 32'hC8);
		wr(OFS_FIX_TGT, 32'h1F4);
		wr(OFS_CTRL, 32'h100);
		beats(2);
		chk("cutoff zero", 32'h0, freq_cmd_ff);
		wr(OFS_REV_CUT, 32'h12C);
		beats(2);
		chk("cutoff", 32'hFFFFFED4, freq_cmd_ff);
		wr(OFS_REV_CUT, 32'h1388);
		beats(2);
		chk("reverse action", 32'hFFFFFE0C, freq_cmd_ff);
		wr(OFS_CTRL, 32'h0);
		dir_reverse_in <= 1'b1;
		beats(2);
		chk("pin reversal", 32'hFFFFFE0C, freq_cmd_ff);
		@(posedge mclk);
		dir_reverse_in <= 1'b0;
		beats(2);
		chk("pin released", 32'h1F4, freq_cmd_ff);
	endtask

	// Dead band hold, then target ramp and clamp.
	task automatic t_band_ramp;
		wr(OFS_DEV_LIM, 32'h258);
		u_ppr_source_model.set_src(16'h00C8, 16'h012C, 16'h007B, 16'h01C8, 16'h0315);
		beats(2);
		chk("band hold", 32'h1F4, freq_cmd_ff);
		wr(OFS_DEV_LIM, 32'h0);
		beats(2);
		chk("band off", 32'h12C, freq_cmd_ff);
		wr(OFS_RAMP_T, 32'h64);
		wr(OFS_FIX_TGT, 32'h258);
		beats(5);
		rd(OFS_ST_TGT, 32'h0, "");
		chk("ramp midway", 1'b1, (v > 32'h1F4 && v < 32'h258));
		beats(60);
		rd(OFS_ST_TGT, 32'h258, "ramp end");
		wr(OFS_FIX_TGT, 32'h7D0);
		rd(OFS_FIX_TGT, 32'h3E8, "target clamp");
	endtask

	// Integral, limited differential and both low-pass filters.
	task automatic t_terms;
		wr(OFS_RAMP_T, 32'h0);
		wr(OFS_KP, 32'h0);
		wr(OFS_TI, 32'h64);
		beats(3);
		chk("integral", 32'h10, freq_cmd_ff);
		wr(OFS_TI, 32'h0);
		wr(OFS_TD, 32'h3E8);
		wr(OFS_FB_FILT, 32'h1);
		u_ppr_source_model.set_src(16'h03E8, 16'h012C, 16'h007B, 16'h01C8, 16'h0315);
		beats(2);
		chk("differential limit", 32'hFFFFFFE7, freq_cmd_ff);
		rd(OFS_ST_FB, 32'h0, "");
		chk("feedback filter", 1'b1, (v > 32'hC8 && v < 32'h3E8));
		wr(OFS_TD, 32'h0);
		wr(OFS_FB_FILT, 32'h0);
		wr(OFS_FIX_TGT, 32'h1F4);
		beats(2);
		wr(OFS_OUT_FILT, 32'h1);
		wr(OFS_KP, 32'h3E8);
		beats(2);
		chk("output filter", 1'b1, (freq_cmd_ff < 0 && freq_cmd_ff > -2500));
	endtask

	initial
	begin
		mclk = 1'b0;
		reset_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		dir_reverse_in = 1'b0;
		n_errors = 0;
		n_compared = 0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		t_defaults();
		t_sources();
		t_action();
		t_band_ramp();
		t_terms();
		conclude();
	end
endmodule
